// File: design/dma_ctl_pkg.sv
package dma_ctl_pkg;

  localparam int NUM_CH = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets (byte addresses on the plain register port)
  localparam logic [7:0] OFS_CH_CTL0 = 8'h00;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h84;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h88;

  // field positions inside channel_control
  localparam int BIT_START = 31;
  localparam int BIT_ABN_EN = 22;
  localparam int BIT_RSV21 = 21;
  localparam int BIT_BIG = 17;
  localparam int BIT_EXT = 14;
  localparam int BIT_EDGE = 13;
  localparam int BIT_LEVEL = 12;
  localparam int BIT_SNOOP = 11;
  localparam int BIT_BUS_RELEASE_RESPONSE_ENABLE = 10;

  localparam logic [31:0] CTL_RESET = 32'h00e20000;
  localparam logic [31:0] CTL_WR_MASK = 32'h7fffffff;

  // interrupt status / mask layout
  localparam int IRQ_W = 5;
  localparam int IRQ_BIT_RELEASE = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

  typedef struct packed {
    logic start;
    logic [5:0] rsv_30_25;
    logic rsv_24;
    logic normal_irq_en;
    logic abnormal_done_irq_enable;
    logic rsv_21;
    logic [2:0] rsv_20_18;
    logic big_endian;
    logic [1:0] rsv_16_15;
    logic request_source_select;
    logic request_edge_select;
    logic level_mode;
    logic snoop_bus_mode;
    logic bus_release_response_enable;
    logic [9:0] xfer_fields;
  } chan_ctl_s;

  // bus ownership signals from the system bus arbiter / core
  typedef struct packed {
    logic granted;
    logic [1:0] owner_ch;
    logic release_req;
    logic bus_break;
  } bus_ctl_s;

  typedef enum logic [1:0] {
    REL_IDLE = 2'b00,
    REL_OWN = 2'b01,
    REL_PEND = 2'b10
  } rel_state_e;

endpackage : dma_ctl_pkg

// File: design/dma_channel_control_fields.sv
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
// Contract
// RQ1: bit 22 gates the channel's abnormal-completion interrupt and resets to 1.
// RQ2: reserved bit 21 resets to 1 although software always writes it as 0.
// RQ3: software writes 0 to reserved bits 20, 19, 18, 16 and 15.
// RQ4: bit 17 selects big endian when 1, little endian when 0, and resets to 1.
// RQ5: bit 14 picks the external request input when 1, the internal start when 0, reset 0.
// RQ6: bit 13 sets polarity or edge of the external request, only while bit 14 is 1, reset 0.
// RQ7: bit 12 picks level or edge sensing, only while bit 14 is 1, reset 0.
// RQ8: software programs the edge bit to 0 and the level bit to 1; the testbench also programs channel 1 with the edge bit at 1.
// RQ9: bit 11 selects snoop acquisition when 1 and grant acquisition when 0, reset 0.
// RQ10: bit 10 enables release responses, resets to 0, and acts only in grant mode.
// RQ11: with responses enabled the bus is handed back at the next break once the core asks.
module dma_channel_control_fields
  import dma_ctl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_CH-1:0] external_transfer_request_in,
  input wire logic [NUM_CH-1:0] soft_request,
  input wire logic [NUM_CH-1:0] abnormal_done,
  input wire bus_ctl_s bus_in,
  output logic [NUM_CH-1:0] xfer_request,
  output logic [NUM_CH-1:0] snoop_acquire_mode,
  output logic [NUM_CH-1:0] big_endian_mode,
  output logic bus_release,
  output logic irq
);

  function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input int ch);
    ch_hit = (a == 8'(OFS_CH_CTL0 + ch * OFS_CH_STRIDE));
  endfunction : ch_hit

  chan_ctl_s ctl_ff [NUM_CH];
  chan_ctl_s nxt_ctl [NUM_CH];
  logic [NUM_CH-1:0] req_prev_ff, nxt_req_prev;
  logic [NUM_CH-1:0] xfer_req_ff, nxt_xfer_req;
  logic [NUM_CH-1:0] snoop_ff, nxt_snoop;
  logic [NUM_CH-1:0] big_ff, nxt_big;
  logic [IRQ_W-1:0] status_ff, nxt_status;
  logic [IRQ_W-1:0] mask_ff, nxt_mask;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  rel_state_e rel_ff, nxt_rel;
  logic release_ff, nxt_release;
  logic release_ok;
  logic [IRQ_W-1:0] irq_events;
  logic [NUM_CH-1:0] ext_qual;

  // channel control registers and per-channel mode outputs
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      nxt_ctl[i] = ctl_ff[i];
      if (reg_wr && ch_hit(reg_addr, i)) begin
        nxt_ctl[i] = chan_ctl_s'(reg_wdata & CTL_WR_MASK);
      end
      nxt_big[i] = ctl_ff[i].big_endian; // see RQ4
      nxt_snoop[i] = ctl_ff[i].snoop_bus_mode; // see RQ9
    end
  end

  // external request qualification: level or edge, polarity per bit 13
  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : g_req
      logic lvl_hit, edge_hit;
      assign lvl_hit = external_transfer_request_in[g] == ctl_ff[g].request_edge_select;
      assign edge_hit = ctl_ff[g].request_edge_select
          ? (external_transfer_request_in[g] && !req_prev_ff[g])
          : (!external_transfer_request_in[g] && req_prev_ff[g]);
      assign ext_qual[g] = ctl_ff[g].level_mode ? lvl_hit : edge_hit; // see RQ6 see RQ7
    end
  endgenerate

  always_comb begin
    nxt_req_prev = external_transfer_request_in;
    for (int i = 0; i < NUM_CH; i++) begin
      // edge and level bits are only consulted in external mode
      nxt_xfer_req[i] = ctl_ff[i].request_source_select ? ext_qual[i] : soft_request[i]; // see RQ5
    end
  end

  // bus release handling for the channel that owns the bus
  assign release_ok = ctl_ff[bus_in.owner_ch].bus_release_response_enable
      && !ctl_ff[bus_in.owner_ch].snoop_bus_mode; // see RQ10

  always_comb begin
    nxt_rel = rel_ff;
    nxt_release = 1'b0;
    unique case (rel_ff)
      REL_IDLE: begin
        if (bus_in.granted) begin
          nxt_rel = REL_OWN;
        end
      end
      REL_OWN: begin
        if (!bus_in.granted) begin
          nxt_rel = REL_IDLE;
        end else if (bus_in.release_req && release_ok) begin
          nxt_rel = REL_PEND; // see RQ11
        end
      end
      REL_PEND: begin
        if (!bus_in.granted) begin
          nxt_rel = REL_IDLE;
        end else if (bus_in.bus_break) begin
          nxt_rel = REL_IDLE;
          nxt_release = 1'b1; // see RQ11
        end
      end
      default: begin
        nxt_rel = REL_IDLE;
      end
    endcase
  end

  // interrupt status, mask and read path
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      irq_events[i] = abnormal_done[i] && ctl_ff[i].abnormal_done_irq_enable; // see RQ1
    end
    irq_events[IRQ_BIT_RELEASE] = release_ff;
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    if (reg_wr && reg_addr == OFS_IRQ_STATUS) begin
      nxt_status = status_ff & ~reg_wdata[IRQ_W-1:0];
    end
    if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
      nxt_mask = reg_wdata[IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    nxt_status = nxt_status | irq_events;
    nxt_irq = |(nxt_status & nxt_mask);
    nxt_rdata = '0;
    if (reg_rd) begin
      if (reg_addr == OFS_IRQ_STATUS) begin
        nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, status_ff};
      end else if (reg_addr == OFS_IRQ_MASK) begin
        nxt_rdata = {{(DATA_W-IRQ_W){1'b0}}, mask_ff};
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_hit(reg_addr, i)) begin
          nxt_rdata = 32'(ctl_ff[i]);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ctl_ff[i] <= chan_ctl_s'(CTL_RESET); // see RQ1 see RQ2 see RQ4
      end
      req_prev_ff <= '0;
      xfer_req_ff <= '0;
      snoop_ff <= '0;
      big_ff <= '1;
      status_ff <= IRQ_RESET;
      mask_ff <= IRQ_RESET;
      rdata_ff <= '0;
      irq_ff <= 1'b0;
      rel_ff <= REL_IDLE;
      release_ff <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        ctl_ff[i] <= nxt_ctl[i];
      end
      req_prev_ff <= nxt_req_prev;
      xfer_req_ff <= nxt_xfer_req;
      snoop_ff <= nxt_snoop;
      big_ff <= nxt_big;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
      rel_ff <= nxt_rel;
      release_ff <= nxt_release;
    end
  end

  assign reg_rdata = rdata_ff;
  assign xfer_request = xfer_req_ff;
  assign snoop_acquire_mode = snoop_ff;
  assign big_endian_mode = big_ff;
  assign bus_release = release_ff;
  assign irq = irq_ff;

  // checks on channel 0 and the release path
  chk_ctl_reset_value: assert property (@(posedge ref_clk) // see RQ2
    !rst_b |=> (ctl_ff[0].rsv_21 && ctl_ff[0].abnormal_done_irq_enable
      && ctl_ff[0].big_endian && !ctl_ff[0].request_source_select
      && !ctl_ff[0].snoop_bus_mode && !ctl_ff[0].bus_release_response_enable))
    else $error("channel control reset value wrong");

  chk_abn_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ1
    $rose(status_ff[0]) |-> $past(ctl_ff[0].abnormal_done_irq_enable) && $past(abnormal_done[0]))
    else $error("abnormal status set while disabled");

  chk_endian_follow: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ4
    (reg_wr && reg_addr == OFS_CH_CTL0) |=> ##1 big_endian_mode[0] == $past(reg_wdata[BIT_BIG], 2))
    else $error("endian output does not follow write");

  chk_internal_src: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ5
    !ctl_ff[0].request_source_select |=> xfer_request[0] == $past(soft_request[0]))
    else $error("internal request not followed");

  chk_ext_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ6
    (!ctl_ff[0].request_source_select && !soft_request[0]) |=> !xfer_request[0])
    else $error("external settings leaked into internal mode");

  chk_level_sense: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ7
    (ctl_ff[0].request_source_select && ctl_ff[0].level_mode
      && external_transfer_request_in[0] == ctl_ff[0].request_edge_select) |=> xfer_request[0])
    else $error("level request not raised");

  chk_snoop_mode: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ9
    snoop_acquire_mode[0] == $past(ctl_ff[0].snoop_bus_mode))
    else $error("snoop mode output mismatch");

  chk_release_gate: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ10
    (rel_ff == REL_OWN && bus_in.granted && bus_in.release_req && !release_ok)
      |=> rel_ff == REL_OWN)
    else $error("release accepted while disabled");

  chk_release_break: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ11
    (rel_ff == REL_PEND && bus_in.granted && bus_in.bus_break) |=> bus_release ##1 !bus_release)
    else $error("bus not released at break");

  // extra checks on channel 1, which the request scenarios drive, then on the interrupt level and channel 0 readback
  chk_edge_pulse_rise: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ7
    (ctl_ff[1].request_source_select && !ctl_ff[1].level_mode
      && ctl_ff[1].request_edge_select
      && external_transfer_request_in[1] && !req_prev_ff[1])
      |=> xfer_request[1])
    else $error("rising edge request not raised");

  chk_level_active: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ6
    (ctl_ff[1].request_source_select && ctl_ff[1].level_mode
      && external_transfer_request_in[1] == ctl_ff[1].request_edge_select)
      |=> xfer_request[1])
    else $error("level request on channel 1 not raised");

  chk_level_inactive: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ6
    (ctl_ff[1].request_source_select && ctl_ff[1].level_mode
      && external_transfer_request_in[1] != ctl_ff[1].request_edge_select)
      |=> !xfer_request[1])
    else $error("inactive level raised a request");

  chk_big_follow: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ4
    big_endian_mode[1] == $past(ctl_ff[1].big_endian))
    else $error("endian output of channel 1 mismatch");

  chk_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ1
    irq == |(status_ff & mask_ff))
    else $error("interrupt level does not match status and mask");

  chk_rsv_readback: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ2
    (reg_rd && reg_addr == OFS_CH_CTL0)
      |=> reg_rdata[BIT_RSV21] == $past(ctl_ff[0].rsv_21))
    else $error("reserved bit 21 not read back");

  // snoop mode must never let a release request through
  chk_snoop_no_release: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ10
    (rel_ff == REL_OWN && ctl_ff[bus_in.owner_ch].snoop_bus_mode)
      |=> rel_ff != REL_PEND)
    else $error("release taken in snoop mode");

  chk_release_take: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ11
    (rel_ff == REL_OWN && bus_in.granted && bus_in.release_req && release_ok)
      |=> rel_ff == REL_PEND)
    else $error("enabled release request not taken");

  // the bus is held until the core's traffic shows a break
  chk_release_wait: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ11
    (rel_ff == REL_PEND && bus_in.granted && !bus_in.bus_break)
      |=> (rel_ff == REL_PEND && !bus_release))
    else $error("bus released before a break");

  chk_release_idle: assert property (@(posedge ref_clk) disable iff (!rst_b) // see RQ11
    (rel_ff != REL_PEND) |=> !bus_release)
    else $error("release pulse without pending request");

endmodule : dma_channel_control_fields

// File: tb/core_bus_model.sv
`timescale 1ns/10ps
module core_bus_model
  import dma_ctl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic give,
  input wire logic want_back,
  input wire logic [1:0] owner,
  input wire logic bus_release,
  output bus_ctl_s bus_in
);
  logic back_ff;
  logic [1:0] beat_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      bus_in <= '0;
      back_ff <= 1'b0;
      beat_ff <= 2'h0;
    end else begin
      beat_ff <= beat_ff + 2'h1;
      // a break in bus traffic every fourth cycle
      bus_in.bus_break <= (beat_ff == 2'h3);
      bus_in.owner_ch <= give ? owner : ~owner;
      if (bus_release) begin
        back_ff <= 1'b1;
      end else if (!give) begin
        back_ff <= 1'b0;
      end
      bus_in.granted <= give && !back_ff && !bus_release;
      bus_in.release_req <= want_back && bus_in.granted && !bus_release;
    end
  end
endmodule : core_bus_model

// File: tb/dma_channel_control_fields_tb.sv
`timescale 1ns/10ps
module dma_channel_control_fields_tb;
  import dma_ctl_pkg::*;
  logic ref_clk, rst_b, reg_wr, reg_rd, give, want_back, bus_release, irq;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [NUM_CH-1:0] ext_in, soft_req, abn, xfer_request, snoop_mode, big_mode;
  logic [1:0] owner;
  bus_ctl_s bus_in;
  int n_fail = 0;
  int cmp_count = 0;
  int hits;

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  dma_channel_control_fields i_dma_channel_control_fields (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .external_transfer_request_in(ext_in), .soft_request(soft_req),
    .abnormal_done(abn), .bus_in(bus_in), .xfer_request(xfer_request),
    .snoop_acquire_mode(snoop_mode), .big_endian_mode(big_mode),
    .bus_release(bus_release), .irq(irq));
  core_bus_model i_core_bus_model (.ref_clk(ref_clk), .rst_b(rst_b), .give(give),
    .want_back(want_back), .owner(owner), .bus_release(bus_release), .bus_in(bus_in));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd

  task automatic pulse_abn(input logic [3:0] v);
    @(posedge ref_clk);
    abn <= v;
    @(posedge ref_clk);
    abn <= 4'h0;
    idle(2);
  endtask : pulse_abn

  // counts high cycles of bus_release (sel 0) or channel 1 request (sel 1)
  task automatic count_hi(input int sel, input logic [31:0] exp);
    hits = 0;
    repeat (20) begin
      @(posedge ref_clk);
      #1;
      if ((sel == 0 ? bus_release : xfer_request[1]) === 1'b1) hits++;
    end
    chk("high cycles", exp, hits);
    if (exp != 0 && hits == 0) wrap_up();
  endtask : count_hi

  initial begin
    rst_b = 1'b0;
    {reg_wr, reg_rd, give, want_back} = 4'h0;
    {reg_addr, reg_wdata, owner} = '0;
    {ext_in, soft_req, abn} = '0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk("big_endian_mode", 32'hf, big_mode);
    chk("snoop_acquire_mode", 32'h0, snoop_mode);
    for (int ch = 0; ch < NUM_CH; ch++) begin
      rd(8'(ch * 32), 32'h00e20000);
    end
    rd(8'h90, 32'h0);
    wr(8'h20, 32'h80401000);
    rd(8'h20, 32'h00401000);
    idle(2);
    chk("big_endian_mode", 32'hd, big_mode);
    @(posedge ref_clk);
    soft_req <= 4'h2;
    ext_in <= 4'hf;
    idle(2);
    chk("xfer_request", 32'h2, xfer_request);
    wr(8'h20, 32'h00405000);
    idle(3);
    chk("xfer_request", 32'h0, xfer_request);
    @(posedge ref_clk);
    ext_in <= 4'hd;
    idle(2);
    chk("xfer_request", 32'h2, xfer_request);
    wr(8'h20, 32'h00407000);
    idle(3);
    chk("xfer_request", 32'h0, xfer_request);
    wr(8'h20, 32'h00406000);
    idle(3);
    @(posedge ref_clk);
    ext_in <= 4'hf;
    count_hi(1, 32'h1);
    @(posedge ref_clk);
    soft_req <= 4'h0;
    wr(8'h88, 32'h4);
    pulse_abn(4'hb);
    chk("irq", 32'h0, irq);
    rd(8'h84, 32'hb);
    pulse_abn(4'h4);
    chk("irq", 32'h1, irq);
    wr(8'h84, 32'hf);
    idle(2);
    chk("irq", 32'h0, irq);
    rd(8'h84, 32'h0);
    wr(8'h40, 32'h00001000);
    pulse_abn(4'h4);
    rd(8'h84, 32'h0);
    wr(8'h00, 32'h00401400);
    wr(8'h88, 32'h10);
    @(posedge ref_clk);
    give <= 1'b1;
    idle(2);
    @(posedge ref_clk);
    want_back <= 1'b1;
    count_hi(0, 32'h1);
    chk("irq", 32'h1, irq);
    rd(8'h84, 32'h10);
    wr(8'h84, 32'h10);
    give <= 1'b0;
    wr(8'h00, 32'h00401c00);
    idle(2);
    chk("snoop_acquire_mode", 32'h1, snoop_mode);
    @(posedge ref_clk);
    give <= 1'b1;
    count_hi(0, 32'h0);
    @(posedge ref_clk);
    give <= 1'b0;
    wr(8'h00, 32'h00401000);
    give <= 1'b1;
    count_hi(0, 32'h0);
    wrap_up();
  end
endmodule : dma_channel_control_fields_tb
